// ===== include/eai_defines.vh
`ifndef EAI_DEFINES_VH
`define EAI_DEFINES_VH

// ==========================================================
// Register map (byte addresses)
`define EAI_ADDR_W 8
`define EAI_ADDR_MODE 8'h00
`define EAI_ADDR_STATUS 8'h04
`define EAI_ADDR_MASK 8'h08
`define EAI_ADDR_ENERGY 8'h0C
`define EAI_ENERGY_COUNT 9

// ==========================================================
// Mode register layout
`define EAI_MODE_W 8
`define EAI_MODE_RESET 8'h00
`define EAI_ACTIVE_RULE_LSB 0
`define EAI_REACT_RULE_LSB 2
`define EAI_WIRING_LSB 4
`define EAI_ACT_SRC_BIT 6
`define EAI_REA_SRC_BIT 7

// Reactive accumulation rule codes
`define EAI_RULE_BY_ACTIVE 2'b10

// Wiring codes
`define EAI_WIRE_WYE3 2'b00
`define EAI_WIRE_DELTA3 2'b01
`define EAI_WIRE_WYE2 2'b10
`define EAI_WIRE_DELTA4 2'b11

// ==========================================================
// Status and mask layout
`define EAI_STATUS_W 13
`define EAI_STATUS_RESET 13'h0000
`define EAI_REV_ACT_LSB 6
`define EAI_REV_REA_LSB 10

// ==========================================================
// Datapath widths
`define EAI_SAMPLE_W 16
`define EAI_VEXT_W 18
`define EAI_PROD_W 34
`define EAI_ACC_W 40
`define EAI_ACC_RESET 40'h0000000000
`define EAI_READ_LSB 8
`define EAI_POWER_W 32
`define EAI_DATA_W 32

`endif

// ===== design/eai_energy_acc.v
`timescale 1ns/1ps
`include "eai_defines.vh"

module eai_energy_acc
(
	input wire clock,
	input wire rst_n,
	input wire sample,
	input wire [`EAI_PROD_W-1:0] value,
	output reg [`EAI_ACC_W-1:0] total
);

	// ==========================================================
	// Signed accumulation, contents kept across mode changes
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			total <= `EAI_ACC_RESET;
		else if (sample)
			total <= total + {{(`EAI_ACC_W-`EAI_PROD_W){value[`EAI_PROD_W-1]}}, value};
	end

endmodule

// ===== design/eai_rev_detect.v
`timescale 1ns/1ps
`include "eai_defines.vh"

module eai_rev_detect
(
	input wire clock,
	input wire rst_n,
	input wire sample,
	input wire [3*`EAI_POWER_W-1:0] power,
	output wire [2:0] reversed
);

	// ==========================================================
	// Sign of each phase's selected power
	wire [2:0] negative;
	reg [2:0] prev_negative;
	reg primed;

	assign negative = {power[3*`EAI_POWER_W-1], power[2*`EAI_POWER_W-1],
		power[`EAI_POWER_W-1]};

	// Remember the last sign seen, first sample only primes
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			prev_negative <= 3'h0;
			primed <= 1'b0;
		end
		else if (sample)
		begin
			prev_negative <= negative;
			primed <= 1'b1;
		end
	end

	// One-cycle event on any sign change
	assign reversed = (sample && primed) ? (negative ^ prev_negative) : 3'h0;

endmodule

// ===== design/eai_top.v
`timescale 1ns/1ps
`include "eai_defines.vh"

module eai_top
#(
	parameter HAS_FUNDAMENTAL = 1
)
(
	input wire clock,
	input wire reset_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	output wire irq,
	input wire sample_valid,
	input wire [15:0] volt_a,
	input wire [15:0] volt_b,
	input wire [15:0] volt_c,
	input wire [15:0] curr_a,
	input wire [15:0] curr_b,
	input wire [15:0] curr_c,
	input wire [15:0] curr_q_a,
	input wire [15:0] curr_q_b,
	input wire [15:0] curr_q_c,
	input wire [15:0] volt_rms_a,
	input wire [15:0] volt_rms_b,
	input wire [15:0] volt_rms_c,
	input wire [15:0] curr_rms_a,
	input wire [15:0] curr_rms_b,
	input wire [15:0] curr_rms_c,
	input wire [31:0] act_power_a,
	input wire [31:0] act_power_b,
	input wire [31:0] act_power_c,
	input wire [31:0] fund_act_power_a,
	input wire [31:0] fund_act_power_b,
	input wire [31:0] fund_act_power_c,
	input wire [31:0] react_power_a,
	input wire [31:0] react_power_b,
	input wire [31:0] react_power_c,
	input wire [31:0] fund_react_power_a,
	input wire [31:0] fund_react_power_b,
	input wire [31:0] fund_react_power_c
);

	// ==========================================================
	// Functions
	// Sign-extend a sample to the product operand width
	function [`EAI_VEXT_W-1:0] vext;
		input [`EAI_SAMPLE_W-1:0] s;
		begin
			vext = {{(`EAI_VEXT_W-`EAI_SAMPLE_W){s[`EAI_SAMPLE_W-1]}}, s};
		end
	endfunction

	// Signed product of an extended voltage and a sample
	function [`EAI_PROD_W-1:0] mul;
		input [`EAI_VEXT_W-1:0] a;
		input [`EAI_SAMPLE_W-1:0] b;
		reg signed [`EAI_PROD_W-1:0] pa;
		reg signed [`EAI_PROD_W-1:0] pb;
		begin
			pa = $signed({{(`EAI_PROD_W-`EAI_VEXT_W){a[`EAI_VEXT_W-1]}}, a});
			pb = $signed({{(`EAI_PROD_W-`EAI_SAMPLE_W){b[`EAI_SAMPLE_W-1]}}, b});
			mul = pa * pb;
		end
	endfunction

	// Apply the reactive accumulation rule for one phase
	function [`EAI_PROD_W-1:0] react_rule;
		input [1:0] rule;
		input [`EAI_PROD_W-1:0] rea;
		input [`EAI_PROD_W-1:0] act;
		begin
			if (rule == `EAI_RULE_BY_ACTIVE && act[`EAI_PROD_W-1])
				react_rule = -rea;
			else
				react_rule = rea;
		end
	endfunction

	// ==========================================================
	// Reset release through two flip-flops
	reg rst_meta;
	reg rst_n;

	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ==========================================================
	// Registers
	reg [`EAI_MODE_W-1:0] mode_cfg;
	reg [`EAI_STATUS_W-1:0] status;
	reg [`EAI_STATUS_W-1:0] mask;
	wire [`EAI_STATUS_W-1:0] events;

	wire [1:0] reactive_accum_rule = mode_cfg[`EAI_REACT_RULE_LSB+1:`EAI_REACT_RULE_LSB];
	wire [1:0] wiring_select = mode_cfg[`EAI_WIRING_LSB+1:`EAI_WIRING_LSB];
	wire active_reversal_source = mode_cfg[`EAI_ACT_SRC_BIT];
	wire reactive_reversal_source = mode_cfg[`EAI_REA_SRC_BIT];

	// ==========================================================
	// AHB-Lite slave, zero wait states
	reg dp_valid;
	reg dp_write;
	reg dp_hit;
	reg [`EAI_ADDR_W-1:0] dp_addr;
	wire wr_en;
	wire rd_status;
	reg [`EAI_MODE_W-1:0] next_mode;

	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Capture the address phase
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			dp_valid <= 1'b0;
			dp_write <= 1'b0;
			dp_hit <= 1'b0;
			dp_addr <= `EAI_ADDR_MODE;
		end
		else if (hready)
		begin
			dp_valid <= hsel & htrans[1];
			dp_write <= hwrite;
			dp_hit <= (haddr[31:`EAI_ADDR_W] == 24'h000000);
			dp_addr <= haddr[`EAI_ADDR_W-1:0];
		end
	end

	assign wr_en = dp_valid & dp_write & dp_hit;
	assign rd_status = dp_valid & ~dp_write & dp_hit & (dp_addr == `EAI_ADDR_STATUS);

	// Mode write; source bits held low without fundamentals
	always @*
	begin
		next_mode = hwdata[`EAI_MODE_W-1:0];
		if (HAS_FUNDAMENTAL == 0)
		begin
			next_mode[`EAI_ACT_SRC_BIT] = 1'b0;
			next_mode[`EAI_REA_SRC_BIT] = 1'b0;
		end
	end

	// Mode and mask registers
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mode_cfg <= `EAI_MODE_RESET;
			mask <= `EAI_STATUS_RESET;
		end
		else if (wr_en)
		begin
			if (dp_addr == `EAI_ADDR_MODE)
				mode_cfg <= next_mode;
			if (dp_addr == `EAI_ADDR_MASK)
				mask <= hwdata[`EAI_STATUS_W-1:0];
		end
	end

	// Sticky status; read clears, a new event wins
	always @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			status <= `EAI_STATUS_RESET;
		else
			status <= (rd_status ? `EAI_STATUS_RESET : status) | events;
	end

	assign irq = |(status & mask);

	// ==========================================================
	// Instantaneous products per phase
	reg [`EAI_VEXT_W-1:0] volt_b_eff;
	reg b_zero;
	wire [`EAI_PROD_W-1:0] act_a;
	wire [`EAI_PROD_W-1:0] act_b;
	wire [`EAI_PROD_W-1:0] act_c;
	wire [`EAI_PROD_W-1:0] rea_a;
	wire [`EAI_PROD_W-1:0] rea_b;
	wire [`EAI_PROD_W-1:0] rea_c;
	wire [`EAI_PROD_W-1:0] app_a;
	wire [`EAI_PROD_W-1:0] app_b;
	wire [`EAI_PROD_W-1:0] app_c;
	wire [`EAI_ENERGY_COUNT*`EAI_PROD_W-1:0] feed;

	// Phase B voltage by wiring arrangement
	always @*
	begin
		b_zero = 1'b0;
		case (wiring_select)
			`EAI_WIRE_WYE3:
				volt_b_eff = vext(volt_b);
			`EAI_WIRE_DELTA3:
			begin
				volt_b_eff = vext(volt_b);
				b_zero = 1'b1;
			end
			`EAI_WIRE_WYE2:
				volt_b_eff = -(vext(volt_a) + vext(volt_c));
			`EAI_WIRE_DELTA4:
				volt_b_eff = -vext(volt_a);
			default:
				volt_b_eff = vext(volt_b);
		endcase
	end

	// Phases A and C use their own inputs in every wiring
	assign act_a = mul(vext(volt_a), curr_a);
	assign rea_a = react_rule(reactive_accum_rule, mul(vext(volt_a), curr_q_a), act_a);
	assign app_a = mul(vext(volt_rms_a), curr_rms_a);
	assign act_c = mul(vext(volt_c), curr_c);
	assign rea_c = react_rule(reactive_accum_rule, mul(vext(volt_c), curr_q_c), act_c);
	assign app_c = mul(vext(volt_rms_c), curr_rms_c);

	// Phase B, zeroed for three-wire delta
	assign act_b = b_zero ? {`EAI_PROD_W{1'b0}} : mul(volt_b_eff, curr_b);
	assign rea_b = b_zero ? {`EAI_PROD_W{1'b0}} :
		react_rule(reactive_accum_rule, mul(volt_b_eff, curr_q_b), act_b);
	assign app_b = b_zero ? {`EAI_PROD_W{1'b0}} : mul(vext(volt_rms_b), curr_rms_b);

	// Accumulator order: A act, rea, app, B ..., C ...
	assign feed = {app_c, rea_c, act_c, app_b, rea_b, act_b, app_a, rea_a, act_a};

	// ==========================================================
	// Energy accumulators
	wire [`EAI_ENERGY_COUNT*`EAI_ACC_W-1:0] energy;

	genvar g;
	generate
		for (g = 0; g < `EAI_ENERGY_COUNT; g = g + 1)
		begin : acc
			eai_energy_acc u_acc
			(
				.clock(clock),
				.rst_n(rst_n),
				.sample(sample_valid),
				.value(feed[g*`EAI_PROD_W +: `EAI_PROD_W]),
				.total(energy[g*`EAI_ACC_W +: `EAI_ACC_W])
			);
		end
	endgenerate

	// ==========================================================
	// Reversal detection with selectable source
	wire [3*`EAI_POWER_W-1:0] act_src;
	wire [3*`EAI_POWER_W-1:0] rea_src;
	wire [2:0] act_rev;
	wire [2:0] rea_rev;

	assign act_src = active_reversal_source ?
		{fund_act_power_c, fund_act_power_b, fund_act_power_a} :
		{act_power_c, act_power_b, act_power_a};
	assign rea_src = reactive_reversal_source ?
		{fund_react_power_c, fund_react_power_b, fund_react_power_a} :
		{react_power_c, react_power_b, react_power_a};

	eai_rev_detect u_act_rev
	(
		.clock(clock),
		.rst_n(rst_n),
		.sample(sample_valid),
		.power(act_src),
		.reversed(act_rev)
	);

	eai_rev_detect u_rea_rev
	(
		.clock(clock),
		.rst_n(rst_n),
		.sample(sample_valid),
		.power(rea_src),
		.reversed(rea_rev)
	);

	// Events placed at their status positions
	assign events = ({{(`EAI_STATUS_W-3){1'b0}}, act_rev} << `EAI_REV_ACT_LSB) |
		({{(`EAI_STATUS_W-3){1'b0}}, rea_rev} << `EAI_REV_REA_LSB);

	// ==========================================================
	// Read data mux for the data phase
	reg [`EAI_ADDR_W-1:0] energy_off;
	reg [`EAI_ACC_W-1:0] energy_word;

	always @*
	begin
		energy_off = dp_addr - `EAI_ADDR_ENERGY;
		energy_word = energy[energy_off[`EAI_ADDR_W-1:2]*`EAI_ACC_W +: `EAI_ACC_W];
		hrdata = 32'h00000000;
		if (dp_valid && !dp_write && dp_hit && dp_addr[1:0] == 2'b00)
		begin
			if (dp_addr == `EAI_ADDR_MODE)
				hrdata = {{(`EAI_DATA_W-`EAI_MODE_W){1'b0}}, mode_cfg};
			else if (dp_addr == `EAI_ADDR_STATUS)
				hrdata = {{(`EAI_DATA_W-`EAI_STATUS_W){1'b0}}, status};
			else if (dp_addr == `EAI_ADDR_MASK)
				hrdata = {{(`EAI_DATA_W-`EAI_STATUS_W){1'b0}}, mask};
			else if (dp_addr >= `EAI_ADDR_ENERGY &&
				energy_off[`EAI_ADDR_W-1:2] < `EAI_ENERGY_COUNT)
				hrdata = energy_word[`EAI_READ_LSB +: `EAI_DATA_W];
		end
	end

endmodule

// ===== dv/eai_top_properties.sv
`timescale 1ns/1ps
`include "eai_defines.vh"

// ==========================================================
// Bus and flag checks seen from the top ports
module eai_top_properties
#(
	parameter HAS_FUNDAMENTAL = 1
)
(
	input wire clock,
	input wire reset_n,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	input wire irq,
	input wire sample_valid
);
	logic rd_ph;
	logic wr_ph;
	logic [7:0] ad;
	logic [7:0] mode_sh;
	wire take = hsel && hready && htrans[1];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// Data phase tracking and expected mode contents
	always @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rd_ph <= 1'b0;
			wr_ph <= 1'b0;
			ad <= 8'h00;
			mode_sh <= 8'h00;
		end
		else
		begin
			rd_ph <= take && !hwrite;
			wr_ph <= take && hwrite;
			ad <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hFF; // Upper bits miss
			if (wr_ph && ad == `EAI_ADDR_MODE)
				mode_sh <= HAS_FUNDAMENTAL ? hwdata[7:0] : {2'b00, hwdata[5:0]};
		end
	end

	a_ready_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_rdata_idle: assert property (!rd_ph |-> hrdata == 32'h0)
		else $error("read data outside read data phase");
	a_unmapped_zero: assert property (rd_ph && ad >= 8'h30 |-> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_mode_readback: assert property (rd_ph && ad == 8'h00 |-> hrdata == {24'h0, mode_sh})
		else $error("mode readback wrong");
	a_status_layout: assert property (rd_ph && ad == 8'h04 |-> (hrdata & ~32'h1DC0) == 0)
		else $error("status bit outside flag layout");
	a_flag_cause: assert property ($rose(irq) |-> $past(sample_valid) || $past(wr_ph))
		else $error("irq rose without sample or write");
	a_flag_sticky: assert property ($fell(irq) |-> $past(rd_ph) || $past(wr_ph))
		else $error("irq fell without access");
	a_quiet_irq: assert property (rd_ph && ad == 8'h04 && hrdata == 0 |-> !irq)
		else $error("irq high with empty status");
endmodule

bind eai_top eai_top_properties #(.HAS_FUNDAMENTAL(HAS_FUNDAMENTAL)) eai_top_properties_inst (
	.clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .irq(irq), .sample_valid(sample_valid));

// ===== dv/eai_top_tb.sv
`timescale 1ns/1ps
`include "eai_defines.vh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, e, g); end end

`define EAI_COMMON .clock(clock), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), \
	.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hresp(), \
	.sample_valid(sample_valid), .volt_a(vin[0]), .volt_b(vin[1]), .volt_c(vin[2]), \
	.curr_a(iin[0]), .curr_b(iin[1]), .curr_c(iin[2]), .curr_q_a(qin[0]), \
	.curr_q_b(qin[1]), .curr_q_c(qin[2]), .volt_rms_a(vr[0]), .volt_rms_b(vr[1]), \
	.volt_rms_c(vr[2]), .curr_rms_a(ir[0]), .curr_rms_b(ir[1]), .curr_rms_c(ir[2]), \
	.act_power_a(ap[0]), .act_power_b(ap[1]), .act_power_c(ap[2]), \
	.fund_act_power_a(fap[0]), .fund_act_power_b(fap[1]), .fund_act_power_c(fap[2]), \
	.react_power_a(rp[0]), .react_power_b(rp[1]), .react_power_c(rp[2]), \
	.fund_react_power_a(frp[0]), .fund_react_power_b(frp[1]), .fund_react_power_c(frp[2])

module eai_top_tb;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic sample_valid = 1'b0;
	logic [15:0] vin [3] = '{16'h1000, 16'h2000, 16'h0800};
	logic [15:0] iin [3] = '{16'h0100, 16'h0300, 16'hFE00};
	logic [15:0] qin [3] = '{16'hFF00, 16'h0200, 16'h0400};
	logic [15:0] vr [3] = '{16'h0400, 16'h0500, 16'h0600};
	logic [15:0] ir [3] = '{16'h0100, 16'h0200, 16'h0300};
	logic [31:0] ap [3] = '{default: 32'h1};
	logic [31:0] fap [3] = '{default: 32'h1};
	logic [31:0] rp [3] = '{default: 32'h1};
	logic [31:0] frp [3] = '{default: 32'h1};
	wire hready, hready2, irq;
	wire [31:0] hrdata, hrdata2;
	logic [31:0] rd, rd2;
	logic [7:0] mode = 8'h00;
	logic signed [39:0] acc [9] = '{default: 40'sh0};
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;

	eai_top #(.HAS_FUNDAMENTAL(1)) eai_top_inst (`EAI_COMMON, .hrdata(hrdata),
		.hready(hready), .hreadyout(hready), .irq(irq));
	eai_top #(.HAS_FUNDAMENTAL(0)) eai_top_inst_nofund (`EAI_COMMON, .hrdata(hrdata2),
		.hready(hready2), .hreadyout(hready2), .irq());

	// Clock and hang guard
	always #5 clock = ~clock;
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			num_errors++;
			print_verdict();
		end
	end

	// ==========================================================
	// Bus transfer, sample pulse and expected products
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
		rd2 = hrdata2;
		hsel <= 1'b0;
	endtask

	function automatic logic signed [33:0] prod(input int k);
		logic signed [17:0] v;
		logic signed [33:0] a, p;
		int ph, ty;
		ph = k / 3;
		ty = k % 3;
		v = $signed(vin[ph]);
		if (ph == 1 && mode[5:4] == 2'b10) v = -$signed(vin[0]) - $signed(vin[2]);
		if (ph == 1 && mode[5:4] == 2'b11) v = -$signed(vin[0]);
		a = v * $signed(iin[ph]);
		p = (ty == 0) ? a : (ty == 1) ? v * $signed(qin[ph]) : $signed(vr[ph]) * $signed(ir[ph]);
		if (ty == 1 && mode[3:2] == 2'b10 && a < 0) p = -p;
		if (ph == 1 && mode[5:4] == 2'b01) p = 0;
		return p;
	endfunction

	task pulse();
		@(posedge clock);
		sample_valid <= 1'b1;
		for (int k = 0; k < 9; k++) acc[k] = acc[k] + prod(k);
		@(posedge clock);
		sample_valid <= 1'b0;
	endtask

	// Set sources and signs, sample twice, then check irq and status
	task step(input logic [7:0] md, input logic [2:0] a, fa, r, fr, input logic [12:0] mk, e);
		mode = md;
		xfer(1'b1, `EAI_ADDR_MASK, {19'h0, mk});
		xfer(1'b1, `EAI_ADDR_MODE, {24'h0, md});
		for (int p = 0; p < 3; p++)
		begin
			ap[p] <= a[p] ? 32'hFFFFFFFF : 32'h1;
			fap[p] <= fa[p] ? 32'hFFFFFFFF : 32'h1;
			rp[p] <= r[p] ? 32'hFFFFFFFF : 32'h1;
			frp[p] <= fr[p] ? 32'hFFFFFFFF : 32'h1;
		end
		pulse();
		pulse();
		repeat (2) @(posedge clock);
		`CHK("irq", |(e & mk), irq)
		xfer(1'b0, `EAI_ADDR_STATUS, 32'h0);
		`CHK("status", {19'h0, e}, rd)
	endtask

	task print_verdict();
		if (num_errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		repeat (3) @(posedge clock);
		for (int k = 0; k < 16; k += 4)
		begin
			xfer(1'b0, 8'(k), 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		xfer(1'b1, 8'h30, 32'hFFFFFFFF);
		xfer(1'b0, 8'h30, 32'h0);
		`CHK("unmapped", 32'h0, rd)
		xfer(1'b1, `EAI_ADDR_MODE, 32'hFF);
		xfer(1'b0, `EAI_ADDR_MODE, 32'h0);
		`CHK("mode rw", 32'hFF, rd)
		`CHK("mode nofund", 32'h3F, rd2)
		for (int m = 0; m < 16; m++)
		begin
			mode = {2'b00, 2'(m), 2'(m >> 2), 2'b00};
			xfer(1'b1, `EAI_ADDR_MODE, {24'h0, mode});
			pulse();
			for (int k = 0; k < 9; k++)
			begin
				xfer(1'b0, 8'(`EAI_ADDR_ENERGY + 4 * k), 32'h0);
				`CHK("energy", acc[k][39:8], rd)
			end
		end
		step(8'h00, 3'b000, 3'b000, 3'b000, 3'b000, 13'h1DC0, 13'h0000);
		step(8'h00, 3'b000, 3'b111, 3'b000, 3'b111, 13'h1DC0, 13'h0000);
		step(8'h00, 3'b001, 3'b111, 3'b100, 3'b111, 13'h1DC0, 13'h1040);
		step(8'hC0, 3'b001, 3'b001, 3'b100, 3'b100, 13'h1DC0, 13'h0000);
		step(8'hC0, 3'b001, 3'b010, 3'b100, 3'b100, 13'h1DC0, 13'h00C0);
		step(8'hC0, 3'b001, 3'b010, 3'b100, 3'b000, 13'h0040, 13'h1000);
		step(8'h40, 3'b111, 3'b010, 3'b100, 3'b000, 13'h1DC0, 13'h1000);
		print_verdict();
	end
endmodule
